// File: rtl/meter_event_map.svh
// Register map and bit positions of the metering event status and mask block
// Contract
// - Set status bit 24 when the voltage peak detection period ends.
// - Set status bit 25 when recomputed checksum differs from run-time capture.
// - Status bits 31 to 26 always read zero.
// - Mask bit 0 enables interrupt on bit 30 change, total active energy.
// - Mask bit 1 enables interrupt on bit 30 change, fundamental active energy.
// - Mask bit 2 is reserved and controls nothing.
// - Mask bit 3 enables interrupt on bit 30 change, fundamental reactive energy.
// - Mask bit 4 enables interrupt on bit 30 change, apparent energy.
// - Mask bit 5 enables interrupt at end of line-cycle accumulation.
// - Mask bits 6-8 enable per-phase active power sign change, selectable source.
// - Mask bit 9 enables interrupt on first output sum power sign change.
// - Mask bits 10-12 enable per-phase fundamental reactive sign change.
// - Mask bit 13 enables interrupt on second output sum power sign change.
// - Mask bit 14 enables interrupt on first output pulse start, even disabled.
// - Mask bit 15 enables interrupt on second output falling edge, even disabled.
// - Mask bit 16 enables interrupt on third output falling edge, even disabled.
// - Mask bit 17 enables interrupt when each 8 kHz DSP cycle completes.
// - Reset-complete is unmaskable and pulls the interrupt pin low.
`ifndef METER_EVENT_MAP_SVH
`define METER_EVENT_MAP_SVH
`define MEV_ADDR_STAT_HI 8'h00
`define MEV_ADDR_MASK_LO 8'h04
`define MEV_ADDR_STAT_LO 8'h08
`define MEV_ADDR_MASK_HI 8'h0C
`define MEV_ADDR_ACCUM 8'h10
`define MEV_ADDR_FCFG 8'h14
`define MEV_ADDR_CTRL 8'h18
`define MEV_LO_W 18
`define MEV_BIT_RESET_COMPLETE_FLAG 15
`define MEV_BIT_RSVD_ONE 21
`define MEV_BIT_PEAK 24
`define MEV_BIT_CRC 25
`define MEV_RSVD_LSB 26
`define MEV_BIT_SIGN_SEL 6
`define MEV_BIT_RESV_MASK 2
`define MEV_BIT_LINE_MODE 1
`define MEV_BIT_RUN 0
`define MEV_FCFG_W 12
`define MEV_DIS_LSB 9
`define MEV_SRC1_LSB 0
`define MEV_SRC2_LSB 3
`define MEV_SRC3_LSB 6
`define MEV_ZERO32 32'h00000000
`define MEV_STAT_HI_RST 32'h00208000
`define MEV_HI_LIVE 32'h03008000
`define MEV_MASK_HI_LIVE 32'h03000000
`endif

// File: rtl/meter_event_pkg.sv
// Types shared by the metering event status and mask block
package meter_event_pkg;
  typedef logic [31:0] word_t;
  typedef logic [17:0] lo_vec_t;
  typedef logic [2:0] phase_vec_t;
  typedef logic [11:0] fcfg_t;
endpackage

// File: rtl/meter_event_status_mask.sv
// Event status flags, interrupt masks and Wishbone slave of the metering core
`include "meter_event_map.svh"
module meter_event_status_mask (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Wishbone classic slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Energy accumulator bit 30, one per phase
  input wire logic [2:0] TOTAL_ACT_BIT30,
  input wire logic [2:0] FUND_ACT_BIT30,
  input wire logic [2:0] FUND_REACT_BIT30,
  input wire logic [2:0] APPARENT_BIT30,
  // Power signs, one per phase plus one per output sum, high when negative
  input wire logic [2:0] TOTAL_ACT_SIGN,
  input wire logic [2:0] FUND_ACT_SIGN,
  input wire logic [2:0] FUND_REACT_SIGN,
  input wire logic SUM1_SIGN,
  input wire logic SUM2_SIGN,
  // Datapath event pulses
  input wire logic LINE_CYCLE_DONE,
  input wire logic DSP_CYCLE_DONE,
  input wire logic VOLT_PEAK_PERIOD_DONE,
  input wire logic POWER_MODE_RETURN,
  // Configuration checksum
  input wire logic [31:0] CHECKSUM,
  input wire logic CHECKSUM_VALID,
  // Frequency outputs
  input wire logic [2:0] FREQ_OUT_LEVEL,
  output logic [2:0] FREQ_OUT_PIN,
  output logic [2:0] FREQ_OUT1_SOURCE,
  output logic [2:0] FREQ_OUT2_SOURCE,
  output logic [2:0] FREQ_OUT3_SOURCE,
  // Interrupt pin, active low
  output logic INTERRUPT_PIN_ONE_N
);

  meter_event_pkg::word_t stat_hi_ff;
  meter_event_pkg::lo_vec_t stat_lo_ff;
  meter_event_pkg::lo_vec_t mask_lo_ff;
  meter_event_pkg::word_t mask_hi_ff;
  meter_event_pkg::word_t accum_ff;
  meter_event_pkg::fcfg_t fcfg_ff;
  logic [1:0] ctrl_ff;
  meter_event_pkg::word_t crc_ref_ff;
  logic primed_ff;
  logic [2:0] tot_q_ff, fact_q_ff, frea_q_ff, app_q_ff;
  logic [2:0] asign_q_ff, rsign_q_ff, lvl_q_ff;
  logic sum1_q_ff, sum2_q_ff;
  logic [31:0] dat_ff;
  logic ack_ff;
  logic irq_n_ff;

  meter_event_pkg::lo_vec_t ev_lo;
  meter_event_pkg::word_t ev_hi;
  meter_event_pkg::word_t wmask;
  meter_event_pkg::word_t nxt_rdata;
  logic [2:0] act_sign;
  logic req, wr, crc_bad, any_irq;

  assign req = CYC_I && STB_I && !ack_ff;
  assign wr = req && WE_I;
  assign wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}},
                  {8{SEL_I[0]}}};

  // Source of the per-phase active sign follows the select bit
  assign act_sign = accum_ff[`MEV_BIT_SIGN_SEL] ? FUND_ACT_SIGN
                                                : TOTAL_ACT_SIGN;

  // First cycle after reset only loads history, so no false edge
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      primed_ff <= 1'b0;
      tot_q_ff <= 3'h0;
      fact_q_ff <= 3'h0;
      frea_q_ff <= 3'h0;
      app_q_ff <= 3'h0;
      asign_q_ff <= 3'h0;
      rsign_q_ff <= 3'h0;
      lvl_q_ff <= 3'h7;
      sum1_q_ff <= 1'b0;
      sum2_q_ff <= 1'b0;
    end else begin
      primed_ff <= 1'b1;
      tot_q_ff <= TOTAL_ACT_BIT30;
      fact_q_ff <= FUND_ACT_BIT30;
      frea_q_ff <= FUND_REACT_BIT30;
      app_q_ff <= APPARENT_BIT30;
      asign_q_ff <= act_sign;
      rsign_q_ff <= FUND_REACT_SIGN;
      lvl_q_ff <= FREQ_OUT_LEVEL;
      sum1_q_ff <= SUM1_SIGN;
      sum2_q_ff <= SUM2_SIGN;
    end
  end

  // Low-word events; set regardless of mask, mask only gates the pin
  always_comb begin
    ev_lo = '0;
    ev_lo[0] = |(TOTAL_ACT_BIT30 ^ tot_q_ff);
    ev_lo[1] = |(FUND_ACT_BIT30 ^ fact_q_ff);
    ev_lo[3] = |(FUND_REACT_BIT30 ^ frea_q_ff);
    ev_lo[4] = |(APPARENT_BIT30 ^ app_q_ff);
    ev_lo[5] = LINE_CYCLE_DONE && ctrl_ff[`MEV_BIT_LINE_MODE];
    ev_lo[8:6] = act_sign ^ asign_q_ff;
    ev_lo[9] = SUM1_SIGN ^ sum1_q_ff;
    ev_lo[12:10] = FUND_REACT_SIGN ^ rsign_q_ff;
    ev_lo[13] = SUM2_SIGN ^ sum2_q_ff;
    // Taken before the disable gate so a disabled pin still interrupts
    ev_lo[14] = lvl_q_ff[0] && !FREQ_OUT_LEVEL[0];
    ev_lo[15] = lvl_q_ff[1] && !FREQ_OUT_LEVEL[1];
    ev_lo[16] = lvl_q_ff[2] && !FREQ_OUT_LEVEL[2];
    ev_lo[17] = DSP_CYCLE_DONE;
    if (!primed_ff) begin
      ev_lo = '0;
    end
  end

  assign crc_bad = CHECKSUM_VALID && ctrl_ff[`MEV_BIT_RUN]
                   && (CHECKSUM != crc_ref_ff);

  always_comb begin
    ev_hi = '0;
    ev_hi[`MEV_BIT_RESET_COMPLETE_FLAG] = POWER_MODE_RETURN;
    ev_hi[`MEV_BIT_PEAK] = VOLT_PEAK_PERIOD_DONE;
    ev_hi[`MEV_BIT_CRC] = crc_bad;
  end

  // Sticky flags; a set in the clearing cycle wins over the clear
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      stat_lo_ff <= '0;
    end else if (wr && ADR_I == `MEV_ADDR_STAT_LO) begin
      stat_lo_ff <= (stat_lo_ff & ~(DAT_I[17:0] & wmask[17:0]))
                    | ev_lo;
    end else begin
      stat_lo_ff <= stat_lo_ff | ev_lo;
    end
  end

  // Reset-complete flag comes up set out of every reset
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      stat_hi_ff <= `MEV_STAT_HI_RST;
    end else if (wr && ADR_I == `MEV_ADDR_STAT_HI) begin
      stat_hi_ff <= ((stat_hi_ff & ~(DAT_I & wmask)) | ev_hi)
                    & `MEV_HI_LIVE;
    end else begin
      stat_hi_ff <= (stat_hi_ff | ev_hi) & `MEV_HI_LIVE;
    end
  end

  // Checksum captured when run goes from 0 to 1
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_ff <= 2'h0;
      crc_ref_ff <= `MEV_ZERO32;
    end else if (wr && ADR_I == `MEV_ADDR_CTRL && SEL_I[0]) begin
      ctrl_ff <= DAT_I[1:0];
      if (DAT_I[`MEV_BIT_RUN] && !ctrl_ff[`MEV_BIT_RUN]) begin
        crc_ref_ff <= CHECKSUM;
      end
    end
  end

  // Mask and configuration registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      mask_lo_ff <= '0;
      mask_hi_ff <= `MEV_ZERO32;
      accum_ff <= `MEV_ZERO32;
      fcfg_ff <= '0;
    end else if (wr) begin
      unique case (ADR_I)
        `MEV_ADDR_MASK_LO: mask_lo_ff <= (mask_lo_ff & ~wmask[17:0])
                                         | (DAT_I[17:0] & wmask[17:0]);
        `MEV_ADDR_MASK_HI: mask_hi_ff <= ((mask_hi_ff & ~wmask)
                                          | (DAT_I & wmask))
                                         & `MEV_MASK_HI_LIVE;
        `MEV_ADDR_ACCUM: accum_ff <= (accum_ff & ~wmask) | (DAT_I & wmask);
        `MEV_ADDR_FCFG: fcfg_ff <= (fcfg_ff & ~wmask[11:0])
                                   | (DAT_I[11:0] & wmask[11:0]);
        default: ;
      endcase
    end
  end

  // Disabled pins idle high; sources go out to the pulse datapath
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      FREQ_OUT_PIN <= 3'h7;
    end else begin
      FREQ_OUT_PIN <= FREQ_OUT_LEVEL | fcfg_ff[`MEV_DIS_LSB +: 3];
    end
  end
  assign FREQ_OUT1_SOURCE = fcfg_ff[`MEV_SRC1_LSB +: 3];
  assign FREQ_OUT2_SOURCE = fcfg_ff[`MEV_SRC2_LSB +: 3];
  assign FREQ_OUT3_SOURCE = fcfg_ff[`MEV_SRC3_LSB +: 3];

  // Reserved mask bit kept readable but never gates anything
  assign any_irq = |(stat_lo_ff & mask_lo_ff
                     & ~(18'h1 << `MEV_BIT_RESV_MASK))
                   | |(stat_hi_ff & mask_hi_ff)
                   | stat_hi_ff[`MEV_BIT_RESET_COMPLETE_FLAG];

  // Registered pin; low from reset since reset-complete is set
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      irq_n_ff <= 1'b0;
    end else begin
      irq_n_ff <= !any_irq;
    end
  end
  assign INTERRUPT_PIN_ONE_N = irq_n_ff;

  // Read mux; unmapped addresses read zero and still acknowledge
  always_comb begin
    nxt_rdata = `MEV_ZERO32;
    unique case (ADR_I)
      `MEV_ADDR_STAT_HI: begin
        nxt_rdata = stat_hi_ff;
        // Reserved bit reads as a constant one; reset loads it but the live mask drops it
        nxt_rdata[`MEV_BIT_RSVD_ONE] = 1'b1;
      end
      `MEV_ADDR_MASK_LO: nxt_rdata[17:0] = mask_lo_ff;
      `MEV_ADDR_STAT_LO: nxt_rdata[17:0] = stat_lo_ff;
      `MEV_ADDR_MASK_HI: nxt_rdata = mask_hi_ff;
      `MEV_ADDR_ACCUM: nxt_rdata = accum_ff;
      `MEV_ADDR_FCFG: nxt_rdata[11:0] = fcfg_ff;
      `MEV_ADDR_CTRL: nxt_rdata[1:0] = ctrl_ff;
      default: nxt_rdata = `MEV_ZERO32;
    endcase
  end

  // One wait state: ack one cycle after the request, dropped next cycle
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ack_ff <= 1'b0;
      dat_ff <= `MEV_ZERO32;
    end else begin
      ack_ff <= req;
      if (req && !WE_I) begin
        dat_ff <= nxt_rdata;
      end
    end
  end
  assign ACK_O = ack_ff;
  assign DAT_O = dat_ff;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_peak_flag_set: assert property (VOLT_PEAK_PERIOD_DONE |=>
    stat_hi_ff[`MEV_BIT_PEAK])
    else $error("peak flag not held");
  a_crc_flag_set: assert property (crc_bad |=> stat_hi_ff[`MEV_BIT_CRC])
    else $error("checksum flag not set");
  a_rsvd_read_zero: assert property (ACK_O |-> DAT_O[31:26] == 6'h00)
    else $error("reserved status bits nonzero");
  a_total_change: assert property (primed_ff
    && TOTAL_ACT_BIT30 != $past(TOTAL_ACT_BIT30) |=> stat_lo_ff[0])
    else $error("total energy change missed");
  a_fund_change: assert property (primed_ff
    && FUND_ACT_BIT30 != fact_q_ff
    |=> stat_lo_ff[1]) else $error("fund energy change missed");
  a_mask2_inert: assert property (!stat_lo_ff[`MEV_BIT_RESV_MASK])
    else $error("reserved event bit set");
  a_line_mode_gate: assert property (!ctrl_ff[`MEV_BIT_LINE_MODE]
    && !stat_lo_ff[5]
    |=> !stat_lo_ff[5]) else $error("line event outside line mode");
  a_freq_fall: assert property (primed_ff && $fell(FREQ_OUT_LEVEL[1])
    |=> stat_lo_ff[15]) else $error("freq two edge missed");
  a_dsp_done: assert property (primed_ff && DSP_CYCLE_DONE
    |=> stat_lo_ff[17])
    else $error("dsp done missed");
  a_irq_assert: assert property ((|(stat_lo_ff & mask_lo_ff
    & ~(18'h1 << `MEV_BIT_RESV_MASK))) |=> !INTERRUPT_PIN_ONE_N)
    else $error("irq pin not low");
  a_irq_release: assert property (!any_irq |=> INTERRUPT_PIN_ONE_N)
    else $error("irq pin stuck low");
  a_rst_done_irq: assert property (POWER_MODE_RETURN
    |=> stat_hi_ff[`MEV_BIT_RESET_COMPLETE_FLAG] ##1 !INTERRUPT_PIN_ONE_N)
    else $error("reset done not signalled");

  // Level-change and line-cycle events, one assertion per source
  a_freact_change: assert property (primed_ff
    && FUND_REACT_BIT30 != frea_q_ff |=> stat_lo_ff[3])
    else $error("fund reactive energy change missed");

  a_appar_change: assert property (primed_ff
    && APPARENT_BIT30 != app_q_ff |=> stat_lo_ff[4])
    else $error("apparent energy change missed");

  a_line_done_set: assert property (primed_ff && LINE_CYCLE_DONE
    && ctrl_ff[`MEV_BIT_LINE_MODE] |=> stat_lo_ff[5])
    else $error("line cycle event missed");

  a_act_sign_flip: assert property (primed_ff && act_sign != asign_q_ff
    |=> (stat_lo_ff[8:6] & $past(act_sign ^ asign_q_ff))
        == $past(act_sign ^ asign_q_ff)) else $error("sign flip missed");

  a_sum1_flip: assert property (primed_ff
    && SUM1_SIGN != sum1_q_ff |=> stat_lo_ff[9])
    else $error("sum one sign flip missed");

  a_react_sign_flip: assert property (primed_ff
    && FUND_REACT_SIGN != rsign_q_ff |=> |stat_lo_ff[12:10])
    else $error("reactive sign flip missed");

  a_sum2_flip: assert property (primed_ff
    && SUM2_SIGN != sum2_q_ff |=> stat_lo_ff[13])
    else $error("sum two sign flip missed");

  a_freq_one_fall: assert property (primed_ff
    && $fell(FREQ_OUT_LEVEL[0]) |=> stat_lo_ff[14])
    else $error("freq one edge missed");

  a_freq_three_fall: assert property (primed_ff
    && $fell(FREQ_OUT_LEVEL[2]) |=> stat_lo_ff[16])
    else $error("freq three edge missed");

  // Disable only forces the pin high; the event path is untouched
  a_freq_pin_gate: assert property (primed_ff |-> FREQ_OUT_PIN
    == ($past(FREQ_OUT_LEVEL) | $past(fcfg_ff[`MEV_DIS_LSB +: 3])))
    else $error("freq pin gate wrong");

  a_crc_capture: assert property (wr && ADR_I == `MEV_ADDR_CTRL
    && SEL_I[0] && DAT_I[0] && !ctrl_ff[0] |=> crc_ref_ff == $past(CHECKSUM))
    else $error("checksum not captured");

  a_crc_needs_run: assert property (!ctrl_ff[`MEV_BIT_RUN]
    && !stat_hi_ff[`MEV_BIT_CRC] |=> !stat_hi_ff[`MEV_BIT_CRC])
    else $error("checksum flag while stopped");

  a_peak_quiet: assert property (!VOLT_PEAK_PERIOD_DONE
    && !stat_hi_ff[`MEV_BIT_PEAK] |=> !stat_hi_ff[`MEV_BIT_PEAK])
    else $error("peak flag without event");

  a_rsvd_hi_zero: assert property (stat_hi_ff[31:`MEV_RSVD_LSB]
    == 6'h00) else $error("reserved status bits stored");

  a_hi_mask_irq: assert property (|(stat_hi_ff & mask_hi_ff)
    |=> !INTERRUPT_PIN_ONE_N) else $error("high irq not signalled");

  a_rst_done_low: assert property (stat_hi_ff[`MEV_BIT_RESET_COMPLETE_FLAG]
    |=> !INTERRUPT_PIN_ONE_N) else $error("reset done pin high");

  a_pin_follows: assert property (!INTERRUPT_PIN_ONE_N
    |-> $past(any_irq)) else $error("irq pin low without cause");

  // Bus timing: one wait state, one-cycle acknowledge
  a_ack_after_req: assert property (req |=> ACK_O)
    else $error("request not acknowledged");

  a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
    else $error("ack held too long");

  a_bit21_reads_one: assert property (ACK_O && !WE_I
    && ADR_I == `MEV_ADDR_STAT_HI |-> DAT_O[`MEV_BIT_RSVD_ONE])
    else $error("reserved one bit reads zero");

  a_mask_hi_live: assert property ((mask_hi_ff & ~`MEV_MASK_HI_LIVE)
    == `MEV_ZERO32) else $error("dead high mask bit stored");

  // Events in the history-load cycle must be dropped
  a_first_cycle_quiet: assert property (!primed_ff
    |=> stat_lo_ff == $past(stat_lo_ff)) else $error("false edge at reset");

endmodule

// File: bench/host_mcu_model.sv
// Host controller model: Wishbone classic master for the event block
module host_mcu_model (
  // Clock and answer
  input wire logic clk,
  input wire logic ack,
  // Request
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h00000000;
  end
  // Request held until ack is sampled; no latency assumed
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    @(posedge clk);
    // Only the bench watchdog ends a wait that never sees ack
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the event status and mask block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS, RESET, CYC_I, STB_I, WE_I, ACK_O, SUM1_SIGN, SUM2_SIGN;
  logic LINE_CYCLE_DONE, DSP_CYCLE_DONE, VOLT_PEAK_PERIOD_DONE;
  logic POWER_MODE_RETURN, CHECKSUM_VALID, INTERRUPT_PIN_ONE_N;
  logic [7:0] ADR_I;
  logic [3:0] SEL_I;
  logic [31:0] DAT_I, DAT_O, CHECKSUM;
  logic [2:0] TOTAL_ACT_BIT30, FUND_ACT_BIT30, FUND_REACT_BIT30;
  logic [2:0] APPARENT_BIT30, TOTAL_ACT_SIGN, FUND_ACT_SIGN;
  logic [2:0] FUND_REACT_SIGN, FREQ_OUT_LEVEL;
  int fails, n_compared, seed, b;
  meter_event_pkg::word_t exp_q[$];

  host_mcu_model host_u (.clk(CLK_SYS), .ack(ACK_O), .cyc(CYC_I),
    .stb(STB_I), .we(WE_I), .adr(ADR_I), .sel(SEL_I), .dat(DAT_I));
  meter_event_status_mask dut_u (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .TOTAL_ACT_BIT30(TOTAL_ACT_BIT30), .FUND_ACT_BIT30(FUND_ACT_BIT30),
    .FUND_REACT_BIT30(FUND_REACT_BIT30), .APPARENT_BIT30(APPARENT_BIT30),
    .TOTAL_ACT_SIGN(TOTAL_ACT_SIGN), .FUND_ACT_SIGN(FUND_ACT_SIGN),
    .FUND_REACT_SIGN(FUND_REACT_SIGN), .SUM1_SIGN(SUM1_SIGN),
    .SUM2_SIGN(SUM2_SIGN), .LINE_CYCLE_DONE(LINE_CYCLE_DONE),
    .DSP_CYCLE_DONE(DSP_CYCLE_DONE),
    .VOLT_PEAK_PERIOD_DONE(VOLT_PEAK_PERIOD_DONE),
    .POWER_MODE_RETURN(POWER_MODE_RETURN), .CHECKSUM(CHECKSUM),
    .CHECKSUM_VALID(CHECKSUM_VALID), .FREQ_OUT_LEVEL(FREQ_OUT_LEVEL),
    .FREQ_OUT_PIN(), .FREQ_OUT1_SOURCE(), .FREQ_OUT2_SOURCE(),
    .FREQ_OUT3_SOURCE(), .INTERRUPT_PIN_ONE_N(INTERRUPT_PIN_ONE_N));

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  task automatic check_word(input meter_event_pkg::word_t got, exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected read at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_pin(input logic exp);
    n_compared++;
    if (INTERRUPT_PIN_ONE_N !== exp) begin
      fails++;
      $display("unexpected pin at %0t: got %h exp %h", $time,
        INTERRUPT_PIN_ONE_N, exp);
    end
  endtask
  // Read data is judged by the monitor at the ack edge
  always @(posedge CLK_SYS) begin
    if (ACK_O === 1'b1 && WE_I === 1'b0) begin
      if (exp_q.size() == 0) begin
        check_word(DAT_O, 32'hDEADBEEF);
      end else begin
        check_word(DAT_O, exp_q.pop_front());
      end
    end
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, a, 32'h00000000);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  // Codes below 32 hit the low status word; 47, 56 and 57 hit the high word at bit plus 32, other codes set bit 17
  task automatic inject(input int c);
    logic [2:0] ph;
    ph = 3'h1 << ($unsigned($random(seed)) % 3);
    case (c)
      0: TOTAL_ACT_BIT30 <= TOTAL_ACT_BIT30 ^ ph;
      1: FUND_ACT_BIT30 <= FUND_ACT_BIT30 ^ ph;
      3: FUND_REACT_BIT30 <= FUND_REACT_BIT30 ^ ph;
      4: APPARENT_BIT30 <= APPARENT_BIT30 ^ ph;
      5: LINE_CYCLE_DONE <= 1'b1;
      6, 7, 8: TOTAL_ACT_SIGN[c-6] <= ~TOTAL_ACT_SIGN[c-6];
      9: SUM1_SIGN <= ~SUM1_SIGN;
      10, 11, 12: FUND_REACT_SIGN[c-10] <= ~FUND_REACT_SIGN[c-10];
      13: SUM2_SIGN <= ~SUM2_SIGN;
      14, 15, 16: FREQ_OUT_LEVEL[c-14] <= 1'b0;
      47: POWER_MODE_RETURN <= 1'b1;
      56: VOLT_PEAK_PERIOD_DONE <= 1'b1;
      57: CHECKSUM_VALID <= 1'b1;
      default: DSP_CYCLE_DONE <= 1'b1;
    endcase
    @(posedge CLK_SYS);
    {LINE_CYCLE_DONE, DSP_CYCLE_DONE, VOLT_PEAK_PERIOD_DONE} <= 3'h0;
    {POWER_MODE_RETURN, CHECKSUM_VALID} <= 2'h0;
    FREQ_OUT_LEVEL <= 3'h7;
  endtask
  // Raise one event, see the pin fall, read and clear the flag
  task automatic svc(input logic [7:0] a, input int bit_n,
                     input logic [31:0] base);
    inject(a == 8'h00 ? bit_n + 32 : bit_n);
    wait_n(3);
    check_pin(1'b0);
    rd(a, base | (32'h1 << bit_n));
    host_u.xfer(1'b1, a, 32'h1 << bit_n);
    wait_n(1);
    check_pin(1'b1);
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    wait_n(6000);
    fails++;
    report_and_stop();
  end

  initial begin
    seed = 52;
    {RESET, TOTAL_ACT_BIT30, FUND_ACT_BIT30, FUND_REACT_BIT30} = 10'h200;
    {APPARENT_BIT30, TOTAL_ACT_SIGN, FUND_ACT_SIGN} = 9'h000;
    {FUND_REACT_SIGN, SUM1_SIGN, SUM2_SIGN, LINE_CYCLE_DONE} = 6'h00;
    {DSP_CYCLE_DONE, VOLT_PEAK_PERIOD_DONE, POWER_MODE_RETURN} = 3'h0;
    {CHECKSUM_VALID, FREQ_OUT_LEVEL, CHECKSUM} = 36'h700000000;
    wait_n(3);
    RESET <= 1'b0;
    wait_n(1);
    check_pin(1'b0);
    rd(8'h00, 32'h00208000);
    host_u.xfer(1'b1, 8'h00, 32'h00008000);
    wait_n(1);
    check_pin(1'b1);
    rd(8'hFC, 32'h00000000);
    $display("test reset done");
    host_u.xfer(1'b1, 8'h18, 32'h00000002);
    host_u.xfer(1'b1, 8'h14, 32'hE00 | ($random(seed) & 32'h1FF));
    host_u.xfer(1'b1, 8'h04, 32'h0003FFFF);
    rd(8'h04, 32'h0003FFFF);
    for (b = 0; b < 18; b++) begin
      if (b != 2) begin
        svc(8'h08, b, 32'h00000000);
      end
    end
    $display("test low events done");
    host_u.xfer(1'b1, 8'h04, 32'h00000000);
    inject(17);
    wait_n(3);
    check_pin(1'b1);
    rd(8'h08, 32'h00020000);
    host_u.xfer(1'b1, 8'h08, 32'h00020000);
    $display("test masked event done");
    host_u.xfer(1'b1, 8'h10, 32'h00000040);
    wait_n(2);
    rd(8'h08, 32'h000001C0);
    host_u.xfer(1'b1, 8'h08, 32'h000001C0);
    $display("test sign source done");
    host_u.xfer(1'b1, 8'h0C, 32'h03000000);
    svc(8'h00, 15, 32'h00200000);
    svc(8'h00, 24, 32'h00200000);
    CHECKSUM <= $random(seed);
    host_u.xfer(1'b1, 8'h18, 32'h00000003);
    CHECKSUM <= CHECKSUM ^ 32'h00000001;
    svc(8'h00, 25, 32'h00200000);
    $display("test high events done");
    RESET <= 1'b1;
    wait_n(2);
    RESET <= 1'b0;
    wait_n(1);
    check_pin(1'b0);
    rd(8'h04, 32'h00000000);
    rd(8'h08, 32'h00000000);
    rd(8'h00, 32'h00208000);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
